// [src/psm_pin_state_manager.v]
// PIN disable/enable/unblock command handler with an APB register file.
// Assumes an APB master on REF_CLK; commands are staged in registers and
// launched by the go bit of the command register.
//
// Function
// - Disable carries eight data bytes, no Le
// - Disable P1 bit8 selects replacement key reference
// - Disable P1 00 plain; 01 reserved, rejected
// - Enable drops replacement qualifier to do-not-use
// - Enable refused when enabled or blocked
// - Correct enable reloads counter, marks enabled
// - Wrong enable decrements, stays disabled; BLOCK_SETS_ENABLE enables on the blocking try
// - Three wrong block PIN; only unblock clears; code also reloads the counter on provision and SRST
// - Blocked disabled grants access; blocked enabled denies
// - Unblock allowed unless unblock secret blocked
// - Correct unblock stores PIN, reloads both counters
// - Successful unblock leaves PIN enabled, satisfied
// - Wrong secret decrements, answers 63C9 to 63C0
// - Tenth wrong secret blocks; later tries 6983
// - Wrong secret leaves PIN state untouched
// - Empty unblock is query answering 63CX
// - Query on blocked secret answers 63C0
// - P2 bit8 scope, bits7-6 zero, ref 01-1F; code accepts only 01 to NUM_PINS
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "psm_regs.vh"

module psm_pin_state_manager #(
  parameter NUM_PINS = 8,
  parameter BLOCK_SETS_ENABLE = 0
) (
  // Clock, reset, enable
  input wire REF_CLK,
  input wire SRST,
  input wire CE,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Access condition per PIN
  output reg [NUM_PINS-1:0] ACCESS_OK
);

  localparam IW = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;
  localparam [5:0] NP = NUM_PINS;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [1:0] state_q;
  reg [2:0] op_q;
  reg [7:0] p1_q;
  reg [7:0] p2_q;
  reg [7:0] lc_q;
  reg le_q;
  reg [127:0] data_q;
  reg [15:0] sw_q;
  reg done_q;
  reg [NUM_PINS-1:0] en_q;
  reg [NUM_PINS-1:0] ver_q;
  reg [NUM_PINS*5-1:0] repl_q;
  reg [31:0] usage_q;
  // Secrets have no reset: a power cycle must not forget them
  reg [63:0] pin_val_q [0:NUM_PINS-1];
  reg [63:0] puk_val_q [0:NUM_PINS-1];

  wire [NUM_PINS*2-1:0] pin_cnt_w;
  wire [NUM_PINS*4-1:0] puk_cnt_w;

  // ----------------------------------------
  // Reference decode
  // ----------------------------------------
  wire [4:0] ref_num = p2_q[4:0];
  wire [4:0] ref_m1 = ref_num - 5'h01;
  wire [IW-1:0] idx = ref_m1[IW-1:0];
  wire ref_ok = (p2_q[6:5] == 2'b00) && (ref_num != 5'h00)
                && ({1'b0, ref_num} <= NP);
  wire [1:0] pin_cnt = pin_cnt_w[idx*2 +: 2];
  wire [3:0] puk_cnt = puk_cnt_w[idx*4 +: 4];
  wire pin_blk = (pin_cnt == 2'h0);
  wire puk_blk = (puk_cnt == 4'h0);
  wire [4:0] cur_repl = repl_q[idx*5 +: 5];
  wire pin_match = (data_q[63:0] == pin_val_q[idx]);
  wire puk_match = (data_q[63:0] == puk_val_q[idx]);
  wire [1:0] pin_left = pin_cnt - 2'h1;
  wire [3:0] puk_left = puk_cnt - 4'h1;
  wire p1_dis_ok = (p1_q == 8'h00)
                   || (p1_q[7] && (p1_q[6:5] == 2'b00) && (p1_q[4:0] != 5'h00));

  // ----------------------------------------
  // Command execution decode
  // ----------------------------------------
  reg [15:0] sw_d;
  reg pin_reload;
  reg pin_dec;
  reg puk_reload;
  reg puk_dec;
  reg set_en;
  reg clr_en;
  reg set_ver;
  reg clr_ver;
  reg load_pin;
  reg load_puk;
  reg set_repl;
  reg clr_repl;

  always @* begin
    sw_d = sw_q;
    pin_reload = 1'b0;
    pin_dec = 1'b0;
    puk_reload = 1'b0;
    puk_dec = 1'b0;
    set_en = 1'b0;
    clr_en = 1'b0;
    set_ver = 1'b0;
    clr_ver = 1'b0;
    load_pin = 1'b0;
    load_puk = 1'b0;
    set_repl = 1'b0;
    clr_repl = 1'b0;
    if (state_q == ST_EXEC) begin
      case (op_q)
        `PSM_OP_DISABLE: begin
          if (le_q || (lc_q != `PSM_LC_PIN)) begin
            sw_d = `PSM_SW_BAD_LEN;
          end else if (!p1_dis_ok || !ref_ok) begin
            sw_d = `PSM_SW_BAD_P1P2;
          end else if (!en_q[idx] || pin_blk) begin
            sw_d = `PSM_SW_COND;
          end else if (pin_match) begin
            pin_reload = 1'b1;
            clr_en = 1'b1;
            set_repl = p1_q[7];
            sw_d = `PSM_SW_OK;
          end else begin
            pin_dec = 1'b1;
            clr_ver = (pin_cnt == 2'h1);
            sw_d = {`PSM_SW_RETRY_HI, 2'b00, pin_left};
          end
        end
        `PSM_OP_ENABLE: begin
          if (le_q || (lc_q != `PSM_LC_PIN)) begin
            sw_d = `PSM_SW_BAD_LEN;
          end else if ((p1_q != 8'h00) || !ref_ok) begin
            sw_d = `PSM_SW_BAD_P1P2;
          end else if (en_q[idx] || pin_blk) begin
            sw_d = `PSM_SW_COND;
          end else if (pin_match) begin
            pin_reload = 1'b1;
            set_en = 1'b1;
            set_ver = 1'b1;
            clr_repl = 1'b1;
            sw_d = `PSM_SW_OK;
          end else begin
            pin_dec = 1'b1;
            clr_ver = (pin_cnt == 2'h1);
            // Optional enable when the last try blocks the PIN
            set_en = (BLOCK_SETS_ENABLE != 0) && (pin_cnt == 2'h1);
            sw_d = {`PSM_SW_RETRY_HI, 2'b00, pin_left};
          end
        end
        `PSM_OP_UNBLOCK: begin
          if (le_q || ((lc_q != `PSM_LC_EMPTY) && (lc_q != `PSM_LC_UNBLOCK))) begin
            sw_d = `PSM_SW_BAD_LEN;
          end else if ((p1_q != 8'h00) || !ref_ok) begin
            sw_d = `PSM_SW_BAD_P1P2;
          end else if (lc_q == `PSM_LC_EMPTY) begin
            sw_d = {`PSM_SW_RETRY_HI, puk_cnt};
          end else if (puk_blk) begin
            sw_d = `PSM_SW_BLOCKED;
          end else if (puk_match) begin
            load_pin = 1'b1;
            puk_reload = 1'b1;
            pin_reload = 1'b1;
            set_en = 1'b1;
            set_ver = 1'b1;
            sw_d = `PSM_SW_OK;
          end else begin
            puk_dec = 1'b1;
            sw_d = {`PSM_SW_RETRY_HI, puk_left};
          end
        end
        `PSM_OP_PROVISION: begin
          if (!ref_ok) begin
            sw_d = `PSM_SW_BAD_P1P2;
          end else begin
            load_pin = 1'b1;
            load_puk = 1'b1;
            pin_reload = 1'b1;
            puk_reload = 1'b1;
            set_en = 1'b1;
            clr_ver = 1'b1;
            sw_d = `PSM_SW_OK;
          end
        end
        default: begin
          sw_d = `PSM_SW_BAD_INS;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Retry counters and access per PIN
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
      localparam [IW-1:0] SEL = gi;
      wire hit = (idx == SEL);
      psm_retry_ctr #(.WIDTH(2), .INIT(`PSM_PIN_TRIES)) u_pin_ctr (
        .clk(REF_CLK),
        .srst(SRST),
        .ce(CE),
        .reload(pin_reload && hit),
        .dec(pin_dec && hit),
        .count(pin_cnt_w[gi*2 +: 2])
      );
      psm_retry_ctr #(.WIDTH(4), .INIT(`PSM_PUK_TRIES)) u_puk_ctr (
        .clk(REF_CLK),
        .srst(SRST),
        .ce(CE),
        .reload(puk_reload && hit),
        .dec(puk_dec && hit),
        .count(puk_cnt_w[gi*4 +: 4])
      );
      always @(posedge REF_CLK) begin
        if (SRST) begin
          ACCESS_OK[gi] <= 1'b1;
        end else if (CE) begin
          ACCESS_OK[gi] <= !en_q[gi]
                           || (ver_q[gi] && (pin_cnt_w[gi*2 +: 2] != 2'h0));
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // PIN state and secrets
  // ----------------------------------------
  always @(posedge REF_CLK) begin
    if (SRST) begin
      en_q <= {NUM_PINS{1'b1}};
      ver_q <= {NUM_PINS{1'b0}};
      repl_q <= {(NUM_PINS*5){1'b0}};
      usage_q <= 32'h0000_0000;
    end else if (CE) begin
      if (set_en) begin
        en_q[idx] <= 1'b1;
      end else if (clr_en) begin
        en_q[idx] <= 1'b0;
      end
      if (set_ver) begin
        ver_q[idx] <= 1'b1;
      end else if (clr_ver) begin
        ver_q[idx] <= 1'b0;
      end
      if (set_repl) begin
        repl_q[idx*5 +: 5] <= p1_q[4:0];
        usage_q[p1_q[4:0]] <= 1'b1;
      end else if (clr_repl && (cur_repl != 5'h00)) begin
        repl_q[idx*5 +: 5] <= 5'h00;
        usage_q[cur_repl] <= 1'b0;
      end
    end
  end

  always @(posedge REF_CLK) begin
    if (CE && load_pin) begin
      pin_val_q[idx] <= data_q[127:64];
    end
    if (CE && load_puk) begin
      puk_val_q[idx] <= data_q[63:0];
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Two-cycle access: data is formed in the first, answered in the second
  wire apb_first = PSEL && PENABLE && !PREADY;
  wire apb_done = PSEL && PENABLE && PREADY;
  wire wr_cmd = apb_done && PWRITE && (PADDR == `PSM_ADDR_CMD);
  wire go = wr_cmd && PWDATA[`PSM_CMD_GO_BIT] && (state_q == ST_IDLE);
  // Command and data writes are ignored while a command executes
  wire wr_ok = apb_done && PWRITE && (state_q == ST_IDLE);

  reg [31:0] rdata;
  reg hit_map;

  always @* begin
    rdata = 32'h0000_0000;
    hit_map = 1'b1;
    case (PADDR)
      `PSM_ADDR_CMD: rdata = {4'h0, le_q, op_q, lc_q, p1_q, p2_q};
      `PSM_ADDR_DATA0: rdata = data_q[31:0];
      `PSM_ADDR_DATA1: rdata = data_q[63:32];
      `PSM_ADDR_DATA2: rdata = data_q[95:64];
      `PSM_ADDR_DATA3: rdata = data_q[127:96];
      `PSM_ADDR_STATUS: rdata = {13'h0000, p2_q[7], state_q[1], done_q, sw_q};
      `PSM_ADDR_PINSTAT: begin
        if (ref_ok) begin
          rdata = {(usage_q[cur_repl] ? `PSM_UQ_USE : `PSM_UQ_NOUSE), 3'h0, cur_repl,
                   4'h0, puk_cnt, 2'h0, pin_cnt, ACCESS_OK[idx], puk_blk, pin_blk, en_q[idx]};
        end
      end
      `PSM_ADDR_USAGE: rdata = usage_q;
      default: hit_map = 1'b0;
    endcase
  end

  always @(posedge REF_CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= apb_first;
      PSLVERR <= apb_first && !hit_map;
      if (apb_first && !PWRITE) begin
        PRDATA <= rdata;
      end
    end
  end

  // ----------------------------------------
  // Command staging and sequencing
  // ----------------------------------------
  always @(posedge REF_CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      op_q <= 3'h0;
      p1_q <= 8'h00;
      p2_q <= 8'h00;
      lc_q <= 8'h00;
      le_q <= 1'b0;
      data_q <= 128'h0;
      sw_q <= `PSM_SW_RST;
      done_q <= 1'b0;
    end else if (CE) begin
      case (state_q)
        ST_IDLE: begin
          if (wr_ok) begin
            case (PADDR)
              `PSM_ADDR_CMD: begin
                p2_q <= PWDATA[`PSM_CMD_P2_LSB +: 8];
                p1_q <= PWDATA[`PSM_CMD_P1_LSB +: 8];
                lc_q <= PWDATA[`PSM_CMD_LC_LSB +: 8];
                op_q <= PWDATA[`PSM_CMD_OP_LSB +: 3];
                le_q <= PWDATA[`PSM_CMD_LE_BIT];
                done_q <= 1'b0;
              end
              `PSM_ADDR_DATA0: data_q[31:0] <= PWDATA;
              `PSM_ADDR_DATA1: data_q[63:32] <= PWDATA;
              `PSM_ADDR_DATA2: data_q[95:64] <= PWDATA;
              `PSM_ADDR_DATA3: data_q[127:96] <= PWDATA;
              default: done_q <= done_q;
            endcase
          end
          if (go) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          sw_q <= sw_d;
          done_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // psm_pin_state_manager

// [src/psm_regs.vh]
// Register map, command codes, status words and retry limits of the
// PIN state manager. Assumes inclusion by bare name from src/.
`ifndef PSM_REGS_VH
`define PSM_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PSM_ADDR_CMD 8'h00
`define PSM_ADDR_DATA0 8'h04
`define PSM_ADDR_DATA1 8'h08
`define PSM_ADDR_DATA2 8'h0c
`define PSM_ADDR_DATA3 8'h10
`define PSM_ADDR_STATUS 8'h14
`define PSM_ADDR_PINSTAT 8'h18
`define PSM_ADDR_USAGE 8'h1c

// ----------------------------------------
// Command register fields
// ----------------------------------------
`define PSM_CMD_P2_LSB 0
`define PSM_CMD_P1_LSB 8
`define PSM_CMD_LC_LSB 16
`define PSM_CMD_OP_LSB 24
`define PSM_CMD_LE_BIT 27
`define PSM_CMD_GO_BIT 31

// ----------------------------------------
// Operations
// ----------------------------------------
`define PSM_OP_DISABLE 3'h1
`define PSM_OP_ENABLE 3'h2
`define PSM_OP_UNBLOCK 3'h3
`define PSM_OP_PROVISION 3'h4

// ----------------------------------------
// Lengths, limits and qualifiers
// ----------------------------------------
`define PSM_LC_EMPTY 8'h00
`define PSM_LC_PIN 8'h08
`define PSM_LC_UNBLOCK 8'h10
`define PSM_PIN_TRIES 2'h3
`define PSM_PUK_TRIES 4'ha
`define PSM_UQ_USE 8'h08
`define PSM_UQ_NOUSE 8'h00

// ----------------------------------------
// Status words
// ----------------------------------------
`define PSM_SW_RST 16'h0000
`define PSM_SW_OK 16'h9000
`define PSM_SW_RETRY_HI 12'h63c
`define PSM_SW_BLOCKED 16'h6983
`define PSM_SW_COND 16'h6985
`define PSM_SW_BAD_P1P2 16'h6a86
`define PSM_SW_BAD_LEN 16'h6700
`define PSM_SW_BAD_INS 16'h6d00

`endif

// [src/psm_retry_ctr.v]
// Saturating retry counter with reload; zero means blocked.
// Assumes reload and dec come from logic on the same clock.
`timescale 1ns/1ns

module psm_retry_ctr #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  // Clocking
  input wire clk,
  input wire srst,
  input wire ce,
  // Control
  input wire reload,
  input wire dec,
  // State
  output reg [WIDTH-1:0] count
);

  always @(posedge clk) begin
    if (srst) begin
      count <= INIT;
    end else if (ce) begin
      if (reload) begin
        count <= INIT;
      end else if (dec && (count != {WIDTH{1'b0}})) begin
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // psm_retry_ctr

// [tb/psm_pin_state_manager_checker.sv]
// Concurrent checks on the ports of the PIN state manager.
// Assumes one clock domain and a master that drops psel after pready.
`timescale 1ns/1ns
`include "psm_regs.vh"

module psm_pin_state_manager_checker #(
  parameter NUM_PINS = 8
) (
  // Clock, reset, enable
  input wire REF_CLK,
  input wire SRST,
  input wire CE,
  // APB
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  // Access
  input wire [NUM_PINS-1:0] ACCESS_OK
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // ----
  // Last launched command
  // ----
  logic [31:0] cmd_q;
  always @(posedge REF_CLK) begin
    if (SRST) begin
      cmd_q <= 32'h0;
    end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00 && PWDATA[31]) begin
      cmd_q <= PWDATA;
    end
  end
  wire [2:0] op = cmd_q[26:24];
  wire [7:0] p1 = cmd_q[15:8];
  wire [7:0] p2 = cmd_q[7:0];
  wire [7:0] lc = cmd_q[23:16];
  wire [15:0] sw = PRDATA[15:0];
  wire pin_op = op == 3'h1 || op == 3'h2;
  // Length is judged before the parameters, so those checks gate on it
  wire len_ok = !cmd_q[27] && (pin_op ? lc == 8'h08 : (lc == 8'h00 || lc == 8'h10));
  wire p2_ok = p2[6:5] == 2'h0 && p2[4:0] != 5'h0 && p2[4:0] <= NUM_PINS;
  wire st_rd = PSEL && PENABLE && PREADY && !PWRITE && PADDR == 8'h14 && PRDATA[16];

  a_len_refused: assert property (st_rd && pin_op && !len_ok |-> sw == `PSM_SW_BAD_LEN)
    else $error("bad length not refused");
  a_p1_reserved: assert property (st_rd && op == 3'h1 && len_ok && p1 == 8'h01 |-> sw == 16'h6a86)
    else $error("reserved P1 accepted");
  a_p1_rfu_bits: assert property (st_rd && op == 3'h1 && len_ok && p1[6:5] != 2'h0 |-> sw == 16'h6a86)
    else $error("P1 bits 7-6 accepted");
  a_p2_coding: assert property (st_rd && op != 3'h0 && op < 3'h4 && len_ok && !p2_ok |-> sw == 16'h6a86)
    else $error("bad P2 accepted");
  a_query_answer: assert property (st_rd && op == 3'h3 && lc == 8'h00 && len_ok && p2_ok && p1 == 8'h00
      |-> sw[15:4] == `PSM_SW_RETRY_HI)
    else $error("query not answered with retries");
  a_retry_range: assert property (st_rd && op == 3'h3 && lc == 8'h10 && sw[15:4] == 12'h63c
      |-> sw[3:0] <= 4'h9)
    else $error("retry count above nine");
  a_ready_wait: assert property (CE && PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("pready not after one wait state");
  a_err_unmapped: assert property (PSEL && PENABLE && PREADY && !PWRITE && PADDR > 8'h1c
      |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access without error");
  a_err_with_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("pslverr outside a transfer end");

  c_blocked: cover property (st_rd && op == 3'h3 && sw == 16'h6983);
  c_enabled: cover property (st_rd && op == 3'h2 && sw == 16'h9000);
  c_unmapped: cover property (PSLVERR);
endmodule // psm_pin_state_manager_checker

bind psm_pin_state_manager psm_pin_state_manager_checker #(.NUM_PINS(NUM_PINS)) u_chk (
  .REF_CLK(REF_CLK), .SRST(SRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ACCESS_OK(ACCESS_OK));

// [tb/psm_terminal.sv]
// Terminal model: issues register transfers as an APB master.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/1ns

module psm_terminal (
  // Clock
  input wire clk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the old request
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // psm_terminal

// [tb/psm_pin_state_manager_test.sv]
// Self-checking bench for the PIN state manager, one PIN entry in depth.
// Assumes the terminal model drives APB and CE stays high.
`timescale 1ns/1ns
`include "psm_regs.vh"

module psm_pin_state_manager_test;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [7:0] access_ok;
  logic [63:0] sec, pin, pin2, bad;
  logic [7:0] bad_p2[5] = '{8'h00, 8'h41, 8'h21, 8'h09, 8'h1f};
  int num_errors, samples_checked, seed, i, r;

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  psm_terminal u_term (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  psm_pin_state_manager #(.NUM_PINS(8), .BLOCK_SETS_ENABLE(0)) u_dut (.REF_CLK(ref_clk),
    .SRST(srst), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ACCESS_OK(access_ok));

  // ----
  // Helpers
  // ----
  function automatic [15:0] tries(input int n);
    tries = {`PSM_SW_RETRY_HI, n[3:0]};
  endfunction
  function automatic [31:0] pst_exp(input logic en, pb, sb, acc, input logic [1:0] pc,
      input logic [3:0] uc, input logic [4:0] rr, input logic [7:0] q);
    pst_exp = {q, 3'h0, rr, 4'h0, uc, 2'h0, pc, acc, sb, pb, en};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_term.xfer(1'b1, a, d, rv, e);
  endtask
  task automatic dat(input logic [63:0] a, input logic [63:0] b);
    wr(`PSM_ADDR_DATA0, a[31:0]);
    wr(`PSM_ADDR_DATA1, a[63:32]);
    wr(`PSM_ADDR_DATA2, b[31:0]);
    wr(`PSM_ADDR_DATA3, b[63:32]);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [7:0] p1, p2, lc, input logic le,
      input logic [15:0] exp);
    int n;
    wr(`PSM_ADDR_CMD, {1'b1, 3'h0, le, op, lc, p1, p2});
    n = 0;
    do begin
      u_term.xfer(1'b0, `PSM_ADDR_STATUS, 32'h0, rv, e);
      n++;
    end while (rv[16] !== 1'b1 && n < 8);
    chk({16'h0, rv[15:0]}, {16'h0, exp});
  endtask
  task automatic pst(input logic [31:0] exp);
    u_term.xfer(1'b0, `PSM_ADDR_PINSTAT, 32'h0, rv, e);
    chk(rv & 32'h0000_0fff, exp);
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    complete_run;
  end

  // ----
  // Scenarios
  // ----
  initial begin
    seed = 32'hbcbc57af;
    srst = 1'b1;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    u_term.xfer(1'b0, 8'h20, 32'h0, rv, e);
    chk({e, rv[30:0]}, 32'h8000_0000);
    sec = {$random(seed), $random(seed)};
    pin = {$random(seed), $random(seed)};
    pin2 = {$random(seed), $random(seed)};
    bad = ~pin;
    dat(sec, pin);
    cmd(3'h4, 8'h00, 8'h01, 8'h10, 1'b0, 16'h9000);
    pst(pst_exp(1, 0, 0, 0, 3, 10, 0, 0));
    $display("test reset and provision done");
    cmd(3'h1, 8'h00, 8'h01, 8'h08, 1'b1, 16'h6700);
    cmd(3'h1, 8'h00, 8'h01, 8'h10, 1'b0, 16'h6700);
    cmd(3'h1, 8'h01, 8'h01, 8'h08, 1'b0, 16'h6a86);
    cmd(3'h1, 8'h45, 8'h01, 8'h08, 1'b0, 16'h6a86);
    cmd(3'h1, 8'ha5, 8'h01, 8'h08, 1'b0, 16'h6a86);
    foreach (bad_p2[k]) cmd(3'h1, 8'h00, bad_p2[k], 8'h08, 1'b0, 16'h6a86);
    $display("test parameter coding done");
    dat(bad, pin2);
    cmd(3'h1, 8'h85, 8'h01, 8'h08, 1'b0, tries(2));
    dat(pin, pin2);
    cmd(3'h1, 8'h85, 8'h81, 8'h08, 1'b0, 16'h9000);
    chk(rv[18], 1'b1);
    pst(pst_exp(0, 0, 0, 1, 3, 10, 0, 0));
    u_term.xfer(1'b0, `PSM_ADDR_USAGE, 32'h0, rv, e);
    chk(rv, 32'h20);
    dat(bad, pin2);
    cmd(3'h2, 8'h00, 8'h01, 8'h08, 1'b0, tries(2));
    cmd(3'h2, 8'h00, 8'h01, 8'h08, 1'b0, tries(1));
    pst(pst_exp(0, 0, 0, 1, 1, 10, 0, 0));
    dat(pin, pin2);
    cmd(3'h2, 8'h00, 8'h01, 8'h08, 1'b0, 16'h9000);
    pst(pst_exp(1, 0, 0, 1, 3, 10, 0, 0));
    u_term.xfer(1'b0, `PSM_ADDR_USAGE, 32'h0, rv, e);
    chk(rv, 32'h0);
    cmd(3'h2, 8'h00, 8'h01, 8'h08, 1'b0, 16'h6985);
    $display("test disable and enable done");
    cmd(3'h1, 8'h00, 8'h01, 8'h08, 1'b0, 16'h9000);
    dat(bad, pin2);
    for (i = 2; i >= 0; i--) cmd(3'h2, 8'h00, 8'h01, 8'h08, 1'b0, tries(i));
    pst(pst_exp(0, 1, 0, 1, 0, 10, 0, 0));
    chk(access_ok[0], 1'b1);
    dat(pin, pin2);
    cmd(3'h2, 8'h00, 8'h01, 8'h08, 1'b0, 16'h6985);
    $display("test blocking done");
    cmd(3'h3, 8'h00, 8'h01, 8'h00, 1'b0, tries(10));
    dat(bad, pin);
    for (i = 9; i >= 1; i--) cmd(3'h3, 8'h00, 8'h01, 8'h10, 1'b0, tries(i));
    pst(pst_exp(0, 1, 0, 1, 0, 1, 0, 0));
    dat(sec, pin2);
    cmd(3'h3, 8'h00, 8'h01, 8'h10, 1'b0, 16'h9000);
    pst(pst_exp(1, 0, 0, 1, 3, 10, 0, 0));
    chk(access_ok[0], 1'b1);
    dat(pin2, pin);
    cmd(3'h1, 8'h00, 8'h01, 8'h08, 1'b0, 16'h9000);
    dat(bad, pin);
    for (i = 9; i >= 0; i--) cmd(3'h3, 8'h00, 8'h01, 8'h10, 1'b0, tries(i));
    dat(sec, pin);
    cmd(3'h3, 8'h00, 8'h01, 8'h10, 1'b0, 16'h6983);
    cmd(3'h3, 8'h00, 8'h01, 8'h00, 1'b0, tries(0));
    pst(pst_exp(0, 0, 1, 1, 3, 0, 0, 0));
    $display("test unblock done");
    for (i = 0; i < 8; i++) begin
      r = $random(seed) & 7;
      cmd(3'h3, 8'h00, r + 1, 8'h00, 1'b0, (r == 0) ? tries(0) : tries(10));
      // Unknown op, or a disable whose P2 has a reserved bit set
      cmd((r < 4) ? 3'h0 : 3'h1, 8'h00, (r < 4) ? 8'h01 : (8'h40 | r[7:0]), 8'h08, 1'b0,
          (r < 4) ? 16'h6d00 : 16'h6a86);
    end
    $display("test random queries done");
    complete_run;
  end
endmodule // psm_pin_state_manager_test
